// *** rtl/gpevl_core.sv ***
// general-purpose event status, enable and input-level registers
`timescale 1ns/100ps
`default_nettype none
module gpevl_core
   import gpevl_pkg::*;
(
   input  wire logic                  clk_i,
   input  wire logic                  nrst_i,
   input  wire logic [5:0]            cfg_dword_i,
   input  wire logic                  cfg_wr_i,
   input  wire logic                  cfg_rd_i,
   input  wire logic [3:0]            cfg_be_i,
   input  wire logic [31:0]           cfg_wdata_i,
   output logic      [31:0]           cfg_rdata_o,
   input  wire logic                  zoom_video_on_bit_i,
   input  wire logic [PWR_SEL_W-1:0]  vcc_select_i,
   input  wire logic [PWR_SEL_W-1:0]  vpp_select_i,
   input  wire logic                  vpp_is_12v_i,
   input  wire logic [NUM_INPUTS-1:0] general_input_i,
   input  wire logic [NUM_INPUTS-1:0] input_is_gpi_i,
   input  wire logic                  event_pin_configured_i,
   output logic                       system_event_output_o
);
   // ---------------------------------------------------------------
   // input synchronisers and change detection
   // ---------------------------------------------------------------
   logic [NUM_INPUTS-1:0] in_meta_q;
   logic [NUM_INPUTS-1:0] in_sync_q;
   logic [NUM_INPUTS-1:0] in_prev_q;
   logic [1:0]            settle_q;
   logic                  zv_prev_q;
   logic [PWR_SEL_W-1:0]  vcc_prev_q;
   logic [PWR_SEL_W-1:0]  vpp_prev_q;
   logic                  v12_prev_q;
   logic                  settled;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         in_meta_q <= '0;
         in_sync_q <= '0;
         in_prev_q <= '0;
      end
      else
      begin
         in_meta_q <= general_input_i;
         in_sync_q <= in_meta_q;
         in_prev_q <= in_sync_q;
      end
   end

   // change detectors ignore the first cycles, so a pin held high at reset is not an event
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         settle_q <= '0;
      else if (settle_q != SETTLE_DONE)
         settle_q <= settle_q + 2'h1;
   end
   assign settled = (settle_q == SETTLE_DONE);

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         zv_prev_q  <= 1'b0;
         vcc_prev_q <= '0;
         vpp_prev_q <= '0;
         v12_prev_q <= 1'b0;
      end
      else
      begin
         zv_prev_q  <= zoom_video_on_bit_i;
         vcc_prev_q <= vcc_select_i;
         vpp_prev_q <= vpp_select_i;
         v12_prev_q <= vpp_is_12v_i;
      end
   end

   logic [15:0] evt_set;
   always_comb
   begin
      evt_set                   = '0;
      evt_set[ZV_BIT]           = zoom_video_on_bit_i ^ zv_prev_q;
      evt_set[PWR_BIT]          = (vcc_select_i != vcc_prev_q) ||
                                  (vpp_select_i != vpp_prev_q);
      evt_set[VPP12_BIT]        = vpp_is_12v_i ^ v12_prev_q;
      evt_set[NUM_INPUTS-1:0]   = in_sync_q ^ in_prev_q;
      if (!settled)
         evt_set = '0;
   end

   // ---------------------------------------------------------------
   // status and enable registers
   // ---------------------------------------------------------------
   logic        evt_hit;
   logic [15:0] stat_clr;
   logic [15:0] stat_d;
   logic [15:0] stat_q;
   logic [15:0] en_q;

   assign evt_hit  = cfg_wr_i && (cfg_dword_i == EVT_DWORD);
   assign stat_clr = evt_hit ? (cfg_wdata_i[15:0] & {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}})
                             : 16'h0000;
   // a new event in the clearing cycle wins over the clear
   assign stat_d   = ((stat_q & ~stat_clr) | evt_set) & EVT_IMPL_MASK;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         stat_q <= EVT_RESET;
      else
         stat_q <= stat_d;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         en_q <= EVT_RESET;
      else if (evt_hit)
      begin
         if (cfg_be_i[2])
            en_q[7:0]  <= cfg_wdata_i[23:16] & EVT_IMPL_MASK[7:0];
         if (cfg_be_i[3])
            en_q[15:8] <= cfg_wdata_i[31:24] & EVT_IMPL_MASK[15:8];
      end
   end

   // ---------------------------------------------------------------
   // event output
   // ---------------------------------------------------------------
   logic [15:0] pin_gate;
   logic        evt_raise;
   always_comb
   begin
      pin_gate                 = EVT_IMPL_MASK;
      pin_gate[NUM_INPUTS-1:0] = input_is_gpi_i;
   end
   assign evt_raise = event_pin_configured_i && |(stat_q & en_q & pin_gate);

   // level stays up while any enabled flag that pin_gate passes remains set and event_pin_configured_i is high
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         system_event_output_o <= 1'b0;
      else
         system_event_output_o <= evt_raise;
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [31:0] rd_word;
   always_comb
   begin
      rd_word = '0;
      unique case (cfg_dword_i)
         PM_DWORD:  rd_word[31:24] = PM_DATA_VALUE;
         EVT_DWORD: rd_word = {en_q, stat_q};
         IN_DWORD:  rd_word[NUM_INPUTS-1:0] = in_sync_q;
         default:   rd_word = '0;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cfg_rdata_o <= RDATA_RESET;
      else if (cfg_rd_i)
         cfg_rdata_o <= rd_word;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   property p_pm_zero;
      cfg_rd_i && cfg_dword_i == PM_DWORD |=> cfg_rdata_o[31:24] == 8'h00;
   endproperty
   a_pm_zero: assert property (p_pm_zero) else $error("pm data not zero");

   property p_clear;
      evt_hit && cfg_be_i[0] && cfg_wdata_i[0] && !evt_set[0] |=> !stat_q[0];
   endproperty
   a_clear: assert property (p_clear) else $error("w1c failed");

   property p_set_no_enable;
      settled && (in_sync_q[1] != in_prev_q[1]) |=> stat_q[1];
   endproperty
   a_set_no_enable: assert property (p_set_no_enable) else $error("flag not set");

   property p_zv;
      settled && $changed(zoom_video_on_bit_i) |=> stat_q[ZV_BIT];
   endproperty
   a_zv: assert property (p_zv) else $error("zoom flag missed");

   property p_pwr;
      settled && ($changed(vcc_select_i) || $changed(vpp_select_i)) |=> stat_q[PWR_BIT];
   endproperty
   a_pwr: assert property (p_pwr) else $error("power flag missed");

   property p_v12;
      settled && $changed(vpp_is_12v_i) |=> stat_q[VPP12_BIT];
   endproperty
   a_v12: assert property (p_v12) else $error("12v flag missed");

   property p_pin;
      settled && $changed(general_input_i[4]) ##2 1'b1 |=> ##[0:1] stat_q[4];
   endproperty
   a_pin: assert property (p_pin) else $error("pin flag missed");

   property p_reserved;
      (stat_q & ~EVT_IMPL_MASK) == 16'h0000 && (en_q & ~EVT_IMPL_MASK) == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");

   property p_no_cfg_no_event;
      !event_pin_configured_i |=> !system_event_output_o;
   endproperty
   a_no_cfg_no_event: assert property (p_no_cfg_no_event) else $error("event unrouted");

   // the output lags status by one edge, so a clear taken on the previous edge may still drop it
   property p_hold;
      system_event_output_o && event_pin_configured_i && $stable(en_q) &&
      $stable(input_is_gpi_i) && $past(stat_clr) == 16'h0000 |=> system_event_output_o;
   endproperty
   a_hold: assert property (p_hold) else $error("event dropped");

   property p_gpi_gate;
      (stat_q & en_q & EVT_IMPL_MASK & ~16'h001f) == 16'h0000 &&
      (stat_q[4:0] & en_q[4:0] & input_is_gpi_i) == 5'h00 |=> !system_event_output_o;
   endproperty
   a_gpi_gate: assert property (p_gpi_gate) else $error("ungated event");

   property p_in_level;
      cfg_rd_i && cfg_dword_i == IN_DWORD |=> cfg_rdata_o == {27'h0, $past(in_sync_q)};
   endproperty
   a_in_level: assert property (p_in_level) else $error("input read wrong");

   c_zv_event:  cover property (stat_q[ZV_BIT] && en_q[ZV_BIT] ##1 system_event_output_o);
   c_pin_event: cover property (stat_q[0] && en_q[0] ##1 system_event_output_o);
   c_clear:     cover property (system_event_output_o ##1 evt_hit ##2 !system_event_output_o);
   c_set_win:   cover property (evt_hit && |(stat_clr & evt_set));
endmodule : gpevl_core
`default_nettype wire

// *** rtl/gpevl_pkg.sv ***
// constants for the general-purpose event logic
package gpevl_pkg;
   // ---------------------------------------------------------------
   // configuration-space byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0]  PM_DATA_OFS    = 8'ha7;
   localparam logic [7:0]  EVT_STAT_OFS   = 8'ha8;
   localparam logic [7:0]  EVT_EN_OFS     = 8'haa;
   localparam logic [7:0]  IN_LEVEL_OFS   = 8'hac;
   // dword slots holding the registers above
   localparam logic [5:0]  PM_DWORD       = PM_DATA_OFS[7:2];
   localparam logic [5:0]  EVT_DWORD      = EVT_STAT_OFS[7:2];
   localparam logic [5:0]  IN_DWORD       = IN_LEVEL_OFS[7:2];
   // ---------------------------------------------------------------
   // field layout of status and enable
   // ---------------------------------------------------------------
   localparam int          ZV_BIT         = 15;
   localparam int          PWR_BIT        = 11;
   localparam int          VPP12_BIT      = 8;
   localparam int          NUM_INPUTS     = 5;
   localparam int          PWR_SEL_W      = 3;
   localparam logic [15:0] EVT_IMPL_MASK  = 16'h891f;
   localparam logic [15:0] EVT_RESET      = 16'h0000;
   localparam logic [7:0]  PM_DATA_VALUE  = 8'h00;
   localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
   localparam logic [1:0]  SETTLE_DONE    = 2'h3;
endpackage : gpevl_pkg

// *** test/gpevl_host_model.sv ***
// host-side model that watches the system event line
`timescale 1ns/100ps
`default_nettype none
module gpevl_host_model
(
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic system_event_i,
   output logic      seen_o
);
   // ---------------------------------------------------------------
   // sticky capture
   // ---------------------------------------------------------------
   // a level event may be short, so the host latches it until its own reset
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         seen_o <= 1'b0;
      else if (system_event_i)
         seen_o <= 1'b1;
   end
endmodule : gpevl_host_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the general-purpose event logic
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import gpevl_pkg::*;
   // ---------------------------------------------------------------
   // stimulus and observation
   // ---------------------------------------------------------------
   logic        clk_i  = 1'b0;
   logic        nrst_i = 1'b0;
   logic [5:0]  dw     = 6'h00;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic [3:0]  be     = 4'h0;
   logic [31:0] wdata  = 32'h0;
   logic [31:0] rdata;
   logic        zv     = 1'b0;
   logic [2:0]  vcc    = 3'h0;
   logic [2:0]  vpp    = 3'h0;
   logic        v12    = 1'b0;
   logic [4:0]  gpi    = 5'h00;
   logic [4:0]  is_gpi = 5'h1f;
   logic        gate   = 1'b1;
   logic        evt;
   logic        seen;
   int          n_mismatch = 0;
   int          num_checks = 0;
   always #20 clk_i = ~clk_i;
   gpevl_core i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cfg_dword_i(dw), .cfg_wr_i(wr),
      .cfg_rd_i(rd), .cfg_be_i(be), .cfg_wdata_i(wdata), .cfg_rdata_o(rdata),
      .zoom_video_on_bit_i(zv), .vcc_select_i(vcc), .vpp_select_i(vpp), .vpp_is_12v_i(v12),
      .general_input_i(gpi), .input_is_gpi_i(is_gpi), .event_pin_configured_i(gate),
      .system_event_output_o(evt));
   gpevl_host_model i_host (.clk_i(clk_i), .nrst_i(nrst_i), .system_event_i(evt),
      .seen_o(seen));
   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // an idle edge after each strobe so it is never raised twice in one step
   task automatic wr_reg(input logic [3:0] b, input logic [31:0] d);
      dw = EVT_DWORD;
      be = b;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask : wr_reg
   task automatic chk_rd(input string nm, input logic [5:0] a, input logic [31:0] e);
      dw = a;
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      chk(nm, e, rdata);
      cyc(1);
   endtask : chk_rd
   task automatic chk_evt(input logic e);
      chk("event", {31'h0, e}, {31'h0, evt});
   endtask : chk_evt
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_regs();
      chk_rd("stat_en", EVT_DWORD, 32'h0);
      dw = PM_DWORD;
      chk_rd("pm_data", PM_DWORD, 32'h0);
      wr_reg(4'hc, 32'hffff_ffff);
      chk_rd("enable", EVT_DWORD, {EVT_IMPL_MASK, 16'h0});
      wr_reg(4'hc, 32'h0);
      $display("test regs done");
   endtask : test_regs
   task automatic test_zoom();
      zv = 1'b1;
      cyc(3);
      chk_evt(1'b0);
      chk("host_seen", 32'h0, {31'h0, seen});
      chk_rd("status", EVT_DWORD, 32'h0000_8000);
      wr_reg(4'hc, 32'h8000_0000);
      chk_evt(1'b1);
      gate = 1'b0;
      cyc(2);
      chk_evt(1'b0);
      gate = 1'b1;
      wr_reg(4'h3, 32'h0);
      chk_evt(1'b1);
      wr_reg(4'h3, 32'h0000_8000);
      chk_evt(1'b0);
      chk_rd("status", EVT_DWORD, 32'h8000_0000);
      $display("test zoom done");
   endtask : test_zoom
   task automatic test_power();
      wr_reg(4'hc, 32'h0900_0000);
      vcc = 3'h1;
      cyc(3);
      chk_rd("status", EVT_DWORD, 32'h0900_0800);
      wr_reg(4'h3, 32'h0000_ffff);
      vpp = 3'h2;
      cyc(3);
      chk_rd("status", EVT_DWORD, 32'h0900_0800);
      wr_reg(4'h3, 32'h0000_ffff);
      v12 = 1'b1;
      cyc(3);
      chk_evt(1'b1);
      chk_rd("status", EVT_DWORD, 32'h0900_0100);
      wr_reg(4'hf, 32'h0000_ffff);
      $display("test power done");
   endtask : test_power
   task automatic test_pins();
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
         gpi[i] = ~gpi[i];
         cyc(6);
         chk_rd("status", EVT_DWORD, 32'h1 << i);
         chk_rd("levels", IN_DWORD, {27'h0, gpi});
         wr_reg(4'h3, 32'h0000_ffff);
         cyc(4);
         chk_rd("status", EVT_DWORD, 32'h0);
      end
      // status still sets on a pin that is not an input; only the event is held back
      is_gpi = 5'h00;
      wr_reg(4'hc, 32'h001f_0000);
      gpi[0] = 1'b0;
      cyc(6);
      chk_evt(1'b0);
      is_gpi = 5'h1f;
      cyc(2);
      chk_evt(1'b1);
      chk("host_seen", 32'h1, {31'h0, seen});
      $display("test pins done");
   endtask : test_pins
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   initial
   begin
      cyc(12);
      nrst_i = 1'b1;
      cyc(4);
      test_regs();
      test_zoom();
      test_power();
      test_pins();
      results();
   end
   // whole run needs well under 400 cycles
   initial
   begin
      #200000;
      n_mismatch++;
      results();
   end
endmodule : testbench
`default_nettype wire
